// >>> src/sar_adc_dev.sv
// converter end of the link, with the word fifo used by the controller end
`timescale 1ns/1ps
`default_nettype none

// =========================================================================
// fifo
module sar_fifo #(
    parameter int WIDTH = sar_pkg::SAR_RES_BITS,
    parameter int DEPTH = sar_pkg::SAR_FIFO_DEPTH
) (
    input  wire logic             clock_in,
    input  wire logic             reset_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    import sar_pkg::*;

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic             push;
    logic             pop;

    assign in_ready_out  = (count != CW'(DEPTH));
    assign out_valid_out = (count != '0);
    assign out_data_out  = mem[rd_ptr];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    always_ff @(posedge clock_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            count <= '0;
        end else begin
            unique case ({push, pop})
                2'b10:   count <= count + 1'b1;
                2'b01:   count <= count - 1'b1;
                default: count <= count;
            endcase
        end
    end
endmodule : sar_fifo

// =========================================================================
// converter end
// Behaviour
// - link clock between 10 kHz and variant max
// - each clock phase lasts at least 400 ns
// - capture input at conversion start, then disconnect
// - shift result out serially, MSB first
// - shifted bits belong to current conversion
// - output advances on each falling clock edge
// - controller samples bits on rising clock edge
// - extra clocks give LSB-first repeat, then zeros
// - clock already low when select falls
// - one code step is full scale over 2^N
// - null low bit after second falling edge
// - output released once select rises
// - new conversion only after select high then low
// - select high shuts down all, else analog only
module sar_adc_dev #(
    parameter int RES_BITS   = sar_pkg::SAR_RES_BITS,
    parameter int LEVEL_BITS = sar_pkg::SAR_LEVEL_BITS
) (
    input  wire logic                  CLOCK_IN,
    input  wire logic                  RESET_IN,
    input  wire logic [LEVEL_BITS-1:0] ANALOG_LEVEL_IN,
    sar_link_if.dev                    LINK,
    output logic                       INPUT_TRACKING_OUT,
    output logic                       ANALOG_POWERED_OUT,
    output logic                       DIGITAL_POWERED_OUT,
    output logic      [RES_BITS-1:0]   RESULT_OUT,
    output logic                       RESULT_VALID_OUT
);
    import sar_pkg::*;

    localparam int IW    = (RES_BITS > 1) ? $clog2(RES_BITS) : 1;
    localparam int SHIFT = LEVEL_BITS - RES_BITS;

    sar_dev_state_t          state;
    logic                    sclk;
    logic                    sel_n;
    logic                    sclk_q;
    logic                    sel_q;
    logic                    fall;
    logic                    sel_fall;
    logic [1:0]              fall_cnt;
    logic [IW-1:0]           bit_idx;
    logic [LEVEL_BITS-1:0]   held_level;
    logic [RES_BITS-1:0]     approx;
    logic                    decision;

    assign sclk  = LINK.conversion_shift_clock;
    assign sel_n = LINK.select_or_powerdown_n;

    // =====================================================================
    // pin edges
    // sel_q resets low so a select already low at reset is not a start
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            sclk_q <= 1'b0;
            sel_q  <= 1'b0;
        end else begin
            sclk_q <= sclk;
            sel_q  <= sel_n;
        end
    end

    assign fall     = sclk_q & ~sclk;
    assign sel_fall = sel_q & ~sel_n;

    // =====================================================================
    // successive approximation
    // compares the held level with the trial code scaled to full scale
    function automatic logic sar_decide(
        input logic [LEVEL_BITS-1:0] level,
        input logic [RES_BITS-1:0]   code,
        input logic [IW-1:0]         idx
    );
        logic [RES_BITS-1:0]   trial;
        logic [LEVEL_BITS-1:0] scaled;
        trial      = code;
        trial[idx] = 1'b1;
        scaled     = LEVEL_BITS'(trial) << SHIFT;
        return (level >= scaled);
    endfunction : sar_decide

    assign decision = sar_decide(held_level, approx, bit_idx);

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            held_level <= '0;
        end else if (state == SAR_D_SAMPLE && fall
                     && fall_cnt == 2'(SAR_NULL_FALL - 1)) begin
            held_level <= ANALOG_LEVEL_IN;
        end
    end

    // =====================================================================
    // shift sequencing
    // each bit is decided on the same falling edge that puts it out,
    // so no earlier word ever leaks into this transfer
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            state    <= SAR_D_OFF;
            fall_cnt <= '0;
            bit_idx  <= '0;
            approx   <= '0;
            LINK.data_out      <= 1'b0;
            LINK.data_out_oe_n <= 1'b1;
        end else if (sel_n) begin
            state    <= SAR_D_OFF;
            fall_cnt <= '0;
            LINK.data_out      <= 1'b0;
            LINK.data_out_oe_n <= 1'b1;
        end else begin
            unique case (state)
                SAR_D_OFF: begin
                    if (sel_fall) begin
                        state    <= SAR_D_SAMPLE;
                        fall_cnt <= '0;
                        approx   <= '0;
                    end
                end
                SAR_D_SAMPLE: begin
                    if (fall) begin
                        fall_cnt <= fall_cnt + 1'b1;
                        if (fall_cnt == 2'(SAR_NULL_FALL - 1)) begin
                            state   <= SAR_D_CONVERT;
                            bit_idx <= IW'(RES_BITS - 1);
                            LINK.data_out      <= 1'b0;
                            LINK.data_out_oe_n <= 1'b0;
                        end
                    end
                end
                SAR_D_CONVERT: begin
                    if (fall) begin
                        approx[bit_idx] <= decision;
                        LINK.data_out   <= decision;
                        if (bit_idx == '0) begin
                            state   <= (RES_BITS > 1) ? SAR_D_REPEAT
                                                      : SAR_D_ZERO;
                            bit_idx <= IW'(1);
                        end else begin
                            bit_idx <= bit_idx - 1'b1;
                        end
                    end
                end
                SAR_D_REPEAT: begin
                    if (fall) begin
                        LINK.data_out <= approx[bit_idx];
                        if (bit_idx == IW'(RES_BITS - 1)) begin
                            state <= SAR_D_ZERO;
                        end else begin
                            bit_idx <= bit_idx + 1'b1;
                        end
                    end
                end
                SAR_D_ZERO: begin
                    if (fall) begin
                        LINK.data_out <= 1'b0;
                    end
                end
            endcase
        end
    end

    // =====================================================================
    // finished word to the user side
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            RESULT_OUT       <= '0;
            RESULT_VALID_OUT <= 1'b0;
        end else begin
            RESULT_VALID_OUT <= 1'b0;
            if (!sel_n && state == SAR_D_CONVERT && fall
                && bit_idx == '0) begin
                RESULT_OUT       <= {approx[RES_BITS-1:1], decision};
                RESULT_VALID_OUT <= 1'b1;
            end
        end
    end

    // =====================================================================
    // power and input switch
    // with select low after the word the digital part stays awake and
    // keeps drawing current on every clock edge
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            INPUT_TRACKING_OUT  <= 1'b0;
            ANALOG_POWERED_OUT  <= 1'b0;
            DIGITAL_POWERED_OUT <= 1'b0;
        end else begin
            DIGITAL_POWERED_OUT <= ~sel_n;
            INPUT_TRACKING_OUT  <= ~sel_n && (state == SAR_D_SAMPLE);
            ANALOG_POWERED_OUT  <= ~sel_n && (state == SAR_D_SAMPLE
                                   || state == SAR_D_CONVERT);
        end
    end
endmodule : sar_adc_dev

`default_nettype wire

// >>> src/sar_pkg.sv
// shared constants and types for the serial successive-approximation link
package sar_pkg;

    // =====================================================================
    // widths
    localparam int SAR_RES_BITS   = 12;
    localparam int SAR_LEVEL_BITS = 16;
    localparam int SAR_FIFO_DEPTH = 8;

    // =====================================================================
    // clock and link timing
    localparam int SAR_CLK_HZ         = 100_000_000;
    localparam int SAR_CLK_MHZ        = SAR_CLK_HZ / 1_000_000;
    localparam int SAR_MIN_SCLK_HZ    = 10_000;
    localparam int SAR_MAX_SCLK_HZ_12 = 2_000_000;
    localparam int SAR_MAX_SCLK_HZ_10 = 2_800_000;
    localparam int SAR_MAX_SCLK_HZ_8  = 3_000_000;
    localparam int SAR_MIN_PHASE_NS   = 400;
    // least phase rounds up to whole cycles
    localparam int SAR_MIN_PHASE_CYC  =
        (SAR_MIN_PHASE_NS * SAR_CLK_MHZ + 999) / 1000;
    // longest phase at the lowest clock rate rounds down
    localparam int SAR_MAX_PHASE_CYC  = SAR_CLK_HZ / (2 * SAR_MIN_SCLK_HZ);

    // =====================================================================
    // frame layout, counted in link clock edges after select falls; select-high gap counted in link clock periods
    localparam int SAR_NULL_FALL        = 2;
    localparam int SAR_NULL_RISE        = 3;
    localparam int SAR_SEL_HIGH_PERIODS = 1;

    // =====================================================================
    // states
    typedef enum logic [2:0] {
        SAR_D_OFF,
        SAR_D_SAMPLE,
        SAR_D_CONVERT,
        SAR_D_REPEAT,
        SAR_D_ZERO
    } sar_dev_state_t;

    typedef enum logic [2:0] {
        SAR_H_IDLE,
        SAR_H_LOW,
        SAR_H_HIGH,
        SAR_H_TAIL,
        SAR_H_GAP
    } sar_host_state_t;

    // fastest link clock allowed for a given result width
    function automatic int sar_max_sclk_hz(input int res_bits);
        if (res_bits >= 12) begin
            return SAR_MAX_SCLK_HZ_12;
        end
        if (res_bits >= 10) begin
            return SAR_MAX_SCLK_HZ_10;
        end
        return SAR_MAX_SCLK_HZ_8;
    endfunction : sar_max_sclk_hz

endpackage : sar_pkg

// >>> src/sar_link_if.sv
// three-wire link between converter end and controller end
`timescale 1ns/1ps
`default_nettype none

interface sar_link_if;
    logic conversion_shift_clock;
    logic select_or_powerdown_n;
    logic data_out;
    logic data_out_oe_n;
    logic data_line;

    // a released line is read as high, as by a weak pull-up
    assign data_line = data_out_oe_n ? 1'b1 : data_out;

    modport dev (
        input  conversion_shift_clock,
        input  select_or_powerdown_n,
        output data_out,
        output data_out_oe_n
    );

    modport host (
        output conversion_shift_clock,
        output select_or_powerdown_n,
        input  data_line,
        input  data_out_oe_n
    );
endinterface : sar_link_if

`default_nettype wire

// >>> src/sar_adc_host.sv
// controller end: makes select and link clock, collects words into a fifo
`timescale 1ns/1ps
`default_nettype none

module sar_adc_host #(
    parameter int RES_BITS         = sar_pkg::SAR_RES_BITS,
    parameter int HALF_PERIOD      = sar_pkg::SAR_MIN_PHASE_CYC,
    parameter int MAX_PHASE_CYCLES = sar_pkg::SAR_MAX_PHASE_CYC,
    parameter int SEL_HIGH_PERIODS = sar_pkg::SAR_SEL_HIGH_PERIODS,
    parameter int FIFO_DEPTH       = sar_pkg::SAR_FIFO_DEPTH
) (
    input  wire logic                CLOCK_IN,
    input  wire logic                RESET_IN,
    input  wire logic                RUN_IN,
    sar_link_if.host                 LINK,
    output logic      [RES_BITS-1:0] CODE_OUT,
    output logic                     CODE_VALID_OUT,
    input  wire logic                CODE_READY_IN,
    output logic                     BUSY_OUT,
    output logic                     FRAME_ERROR_OUT
);
    import sar_pkg::*;

    // phase length kept inside the legal clock window
    localparam int FMAX_HALF =
        (SAR_CLK_HZ / sar_max_sclk_hz(RES_BITS) + 1) / 2;
    localparam int PH_A  = (HALF_PERIOD > SAR_MIN_PHASE_CYC)
                           ? HALF_PERIOD : SAR_MIN_PHASE_CYC;
    localparam int PH_B  = (PH_A > FMAX_HALF) ? PH_A : FMAX_HALF;
    localparam int PHASE = (PH_B < MAX_PHASE_CYCLES) ? PH_B : MAX_PHASE_CYCLES;
    localparam int PW    = $clog2(PHASE + 1);
    localparam int GAP   = 2 * PHASE * SEL_HIGH_PERIODS;
    localparam int GW    = $clog2(GAP + 1);
    localparam int LAST_RISE = SAR_NULL_RISE + RES_BITS;
    localparam int RW    = $clog2(LAST_RISE + 1);

    sar_host_state_t       state;
    logic [PW-1:0]         ph_cnt;
    logic [GW-1:0]         gap_cnt;
    logic [RW-1:0]         rise_cnt;
    logic [RW-1:0]         this_rise;
    logic [RES_BITS-1:0]   shreg;
    logic                  push;
    logic                  fifo_ready;
    logic                  phase_done;

    assign phase_done = (ph_cnt == PW'(PHASE - 1));
    assign this_rise  = rise_cnt + 1'b1;
    assign BUSY_OUT   = (state != SAR_H_IDLE);

    // =====================================================================
    // frame sequencing
    // a frame starts only with a free fifo slot, so the push never stalls
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            state    <= SAR_H_IDLE;
            ph_cnt   <= '0;
            gap_cnt  <= '0;
            rise_cnt <= '0;
            push     <= 1'b0;
            LINK.conversion_shift_clock <= 1'b0;
            LINK.select_or_powerdown_n  <= 1'b1;
        end else begin
            push <= 1'b0;
            unique case (state)
                SAR_H_IDLE: begin
                    ph_cnt   <= '0;
                    rise_cnt <= '0;
                    if (RUN_IN && fifo_ready) begin
                        state <= SAR_H_LOW;
                        LINK.select_or_powerdown_n <= 1'b0;
                    end
                end
                SAR_H_LOW: begin
                    ph_cnt <= ph_cnt + 1'b1;
                    if (phase_done) begin
                        ph_cnt   <= '0;
                        rise_cnt <= this_rise;
                        state    <= SAR_H_HIGH;
                        LINK.conversion_shift_clock <= 1'b1;
                    end
                end
                SAR_H_HIGH: begin
                    ph_cnt <= ph_cnt + 1'b1;
                    if (phase_done) begin
                        ph_cnt <= '0;
                        state  <= (rise_cnt == RW'(LAST_RISE)) ? SAR_H_TAIL
                                                               : SAR_H_LOW;
                        LINK.conversion_shift_clock <= 1'b0;
                    end
                end
                SAR_H_TAIL: begin
                    ph_cnt <= ph_cnt + 1'b1;
                    if (phase_done) begin
                        state   <= SAR_H_GAP;
                        gap_cnt <= '0;
                        push    <= 1'b1;
                        LINK.select_or_powerdown_n <= 1'b1;
                    end
                end
                SAR_H_GAP: begin
                    gap_cnt <= gap_cnt + 1'b1;
                    if (gap_cnt == GW'(GAP - 1)) begin
                        state <= SAR_H_IDLE;
                    end
                end
            endcase
        end
    end

    // =====================================================================
    // bit capture, taken just before the clock is raised
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            shreg           <= '0;
            FRAME_ERROR_OUT <= 1'b0;
        end else if (state == SAR_H_LOW && phase_done) begin
            if (this_rise == RW'(SAR_NULL_RISE)) begin
                FRAME_ERROR_OUT <= LINK.data_line | LINK.data_out_oe_n;
            end else if (this_rise > RW'(SAR_NULL_RISE)) begin
                shreg <= {shreg[RES_BITS-2:0], LINK.data_line};
                if (LINK.data_out_oe_n) begin
                    FRAME_ERROR_OUT <= 1'b1;
                end
            end
        end
    end

    // =====================================================================
    // word buffer
    sar_fifo #(
        .WIDTH (RES_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock_in      (CLOCK_IN),
        .reset_in      (RESET_IN),
        .in_valid_in   (push),
        .in_ready_out  (fifo_ready),
        .in_data_in    (shreg),
        .out_valid_out (CODE_VALID_OUT),
        .out_ready_in  (CODE_READY_IN),
        .out_data_out  (CODE_OUT)
    );
endmodule : sar_adc_host

`default_nettype wire

// >>> dv/sar_link_monitor.sv
// link checker: concurrent checks on the three-wire link between both ends
`timescale 1ns/1ps
`default_nettype none

module sar_link_monitor (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic conversion_shift_clock_in,
    input wire logic select_or_powerdown_n_in,
    input wire logic data_out_in,
    input wire logic data_out_oe_n_in,
    input wire logic data_line_in
);
    wire logic conversion_shift_clock = conversion_shift_clock_in;
    wire logic select_or_powerdown_n  = select_or_powerdown_n_in;
    wire logic data_out               = data_out_in;
    wire logic data_out_oe_n          = data_out_oe_n_in;
    wire logic data_line              = data_line_in;
    // =====================================================================
    // helpers: falling clocks in the frame, cycles since the clock moved
    logic       sck_q;
    logic       fall;
    logic [7:0] n_fall;
    logic [7:0] n_ph;

    assign fall = sck_q & ~conversion_shift_clock;

    always_ff @(posedge clock_in) begin
        sck_q <= reset_in ? 1'b0 : conversion_shift_clock;
    end

    // saturate so a stuck-low select never wraps back into the bit window
    always_ff @(posedge clock_in) begin
        if (reset_in || select_or_powerdown_n) begin
            n_fall <= 8'H00;
        end else if (fall && n_fall != 8'HFF) begin
            n_fall <= n_fall + 8'H01;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in || conversion_shift_clock != sck_q) begin
            n_ph <= 8'H01;
        end else if (n_ph != 8'HFF) begin
            n_ph <= n_ph + 8'H01;
        end
    end

    // =====================================================================
    // checks
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);

    clock_low_a: assert property (
        $fell(select_or_powerdown_n) |-> !conversion_shift_clock)
        else $error("link clock high as select fell");
    idle_clock_a: assert property (
        select_or_powerdown_n |-> !conversion_shift_clock)
        else $error("link clock moved outside a frame");
    phase_len_a: assert property (
        !select_or_powerdown_n && conversion_shift_clock != sck_q
        |-> n_ph >= 8'H28)
        else $error("link clock phase shorter than 40 cycles");
    null_low_a: assert property (
        $fell(data_out_oe_n) |-> !data_line)
        else $error("null bit not low");
    enable_at_a: assert property (
        $fell(data_out_oe_n) |-> n_fall == 8'H02)
        else $error("output enabled at wrong falling edge");
    drive_hold_a: assert property (
        !select_or_powerdown_n && n_fall >= 8'H02 |-> !data_out_oe_n)
        else $error("output released inside the frame");
    data_edge_a: assert property (
        $changed(data_out) && !data_out_oe_n && !$past(data_out_oe_n)
        |-> $past(fall))
        else $error("data moved without a falling clock");
    release_a: assert property (
        select_or_powerdown_n [*2] |=> data_out_oe_n)
        else $error("output still driven with select high");
    frame_len_a: assert property (
        $rose(select_or_powerdown_n) |-> n_fall == 8'H0F)
        else $error("frame closed after wrong clock count");
    select_gap_a: assert property (
        $rose(select_or_powerdown_n) |-> select_or_powerdown_n [*8])
        else $error("select high too briefly between frames");

    cover property ($fell(data_out_oe_n));
    cover property ($rose(select_or_powerdown_n));
    cover property (n_fall == 8'H0F);
endmodule : sar_link_monitor

`default_nettype wire

// >>> dv/tb.sv
// self-checking bench: both link ends, fifo traffic, long frame on link two
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    n_fail++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module tb;
    import sar_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        run = 1'b0;
    logic        rdy = 1'b0;
    logic        sel_q = 1'b1;
    logic        sck_q = 1'b0;
    logic [15:0] lvl = 16'H1234;
    logic [15:0] lvl2 = 16'HA5C3;
    logic [15:0] edge_lv [6] = '{16'H0000, 16'HFFFF, 16'H8000,
                                 16'H7FFF, 16'H000F, 16'H0010};
    logic [11:0] code, res, word;
    logic        cval, busy, ferr, rval, trk, dpw, apw;
    int          n_fail = 0;
    int          n_tests = 0;
    int          seed = 32'HDE48F505;
    int          mode = 0;
    int          n_pop = 0;
    int          nfr = 0;
    int          n_rv = 0;
    int          n_rise, cur, ex;
    int          q[$];

    sar_link_if link ();
    sar_link_if link2 ();

    sar_adc_dev u_sar_adc_dev (.CLOCK_IN(clk), .RESET_IN(rst),
        .ANALOG_LEVEL_IN(lvl), .LINK(link.dev), .INPUT_TRACKING_OUT(trk),
        .ANALOG_POWERED_OUT(apw), .DIGITAL_POWERED_OUT(dpw),
        .RESULT_OUT(res), .RESULT_VALID_OUT(rval));
    sar_adc_dev u_sar_adc_dev2 (.CLOCK_IN(clk), .RESET_IN(rst),
        .ANALOG_LEVEL_IN(lvl2), .LINK(link2.dev), .INPUT_TRACKING_OUT(),
        .ANALOG_POWERED_OUT(), .DIGITAL_POWERED_OUT(),
        .RESULT_OUT(), .RESULT_VALID_OUT());
    sar_adc_host u_sar_adc_host (.CLOCK_IN(clk), .RESET_IN(rst),
        .RUN_IN(run), .LINK(link.host), .CODE_OUT(code),
        .CODE_VALID_OUT(cval), .CODE_READY_IN(rdy), .BUSY_OUT(busy),
        .FRAME_ERROR_OUT(ferr));
    sar_link_monitor u_mon (.clock_in(clk), .reset_in(rst),
        .conversion_shift_clock_in(link.conversion_shift_clock),
        .select_or_powerdown_n_in(link.select_or_powerdown_n),
        .data_out_in(link.data_out),
        .data_out_oe_n_in(link.data_out_oe_n),
        .data_line_in(link.data_line));

    // =====================================================================
    // clock, consumer, link two idle levels
    initial begin
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        rdy <= #1 (mode == 1) ? 1'($random(seed)) : (mode == 2);
    end

    // =====================================================================
    // wire watcher and reference model; expected code is level / 16
    always @(posedge clk) begin
        sel_q <= link.select_or_powerdown_n;
        sck_q <= link.conversion_shift_clock;
        if (!rst) begin
            `CHK("dig_pwr", ~sel_q, dpw)
            if (!link.select_or_powerdown_n && sel_q) begin
                n_rise = 0;
                word = 12'H000;
                cur = lvl / 16;
            end
            if (link.conversion_shift_clock && !sck_q) begin
                n_rise++;
                if (n_rise == 3) `CHK("null", 1'b0, link.data_line)
                else if (n_rise >= 4 && n_rise <= 15)
                    word = {word[10:0], link.data_line};
                `CHK("tracking", 1'(n_rise <= 2), trk)
                `CHK("analog_pwr", 1'(n_rise <= 14), apw)
            end
            if (rval) begin
                n_rv++;
                `CHK("result", cur[11:0], res)
            end
            if (link.select_or_powerdown_n && !sel_q) begin
                `CHK("wire_word", cur[11:0], word)
                `CHK("result_count", nfr + 1, n_rv)
                q.push_back(cur);
                lvl <= #1 (nfr < 6) ? edge_lv[nfr] : 16'($random(seed));
                nfr++;
            end
            if (cval === 1'b1 && rdy) begin
                ex = (q.size() > 0) ? q.pop_front() : -1;
                `CHK("fifo_word", ex[11:0], code)
                n_pop++;
            end
        end
    end

    // =====================================================================
    // tasks
    task automatic print_verdict();
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    task automatic wait_until(input int want, input int kind, input string nm);
        int i;
        for (i = 0; i < 30000; i++) begin
            if ((kind == 0 && n_pop >= want)
                || (kind == 1 && q.size() == want)) break;
            @(posedge clk);
        end
        if (i == 30000) begin
            n_fail++;
            $display("MISMATCH %s exp done got timeout", nm);
            print_verdict();
        end else $display("test %s done", nm);
    endtask : wait_until

    // drives link two well past the word to see repeat and zero fill
    task automatic long_frame();
        int f;
        logic [11:0] w;
        logic e;
        w = lvl2[15:4];
        @(posedge clk);
        link2.select_or_powerdown_n <= #1 1'b0;
        for (f = 1; f <= 30; f++) begin
            repeat (40) @(posedge clk);
            e = (f < 3) ? 1'b1 : (f == 3) ? 1'b0 : (f <= 15) ? w[15-f] :
                (f <= 26) ? w[f-15] : 1'b0;
            `CHK("long_bit", e, link2.data_line)
            link2.conversion_shift_clock <= #1 1'b1;
            repeat (40) @(posedge clk);
            link2.conversion_shift_clock <= #1 1'b0;
        end
        repeat (40) @(posedge clk);
        link2.select_or_powerdown_n <= #1 1'b1;
        repeat (3) @(posedge clk);
        `CHK("released", 1'b1, link2.data_out_oe_n)
        $display("test long_frame done");
    endtask : long_frame

    // =====================================================================
    // main sequence
    initial begin
        link2.select_or_powerdown_n = 1'b1;
        link2.conversion_shift_clock = 1'b0;
        repeat (16) @(posedge clk);
        rst <= #1 1'b0;
        run <= #1 1'b1;
        mode = 1;
        wait_until(12, 0, "stream");
        mode = 0;
        wait_until(8, 1, "fill");
        repeat (3000) @(posedge clk);
        `CHK("stall_busy", 1'b0, busy)
        `CHK("fill_count", 8, q.size())
        run <= #1 1'b0;
        mode = 2;
        wait_until(0, 1, "drain");
        @(posedge clk);
        `CHK("drained", 1'b0, cval)
        `CHK("frame_err", 1'b0, ferr)
        long_frame();
        print_verdict();
    end
endmodule : tb

`default_nettype wire
